// File: rtl/cpo_top.v
// Purpose: Write-once clock source, range, slew and pin option registers
// Assumes: Inputs synchronous to clk; reads answer one cycle later
// Notes:   Every output is registered, so options reach pins one
//          cycle after the register updates
//
// Overview of operation
// [RULE1] Crystal enable needs external clock enable
// [RULE2] Oscillator pin function decodes from both enables
// [RULE3] Crystal enable selects monitor crystal frequency ranges
// [RULE4] Stabilization timeout 4096 crystal, 16 otherwise
// [RULE5] Slow select picks crystal mode and monitor band
// [RULE6] Timebase prescale select inserts divide by 128
// [RULE7] Run-in-stop keeps clocks; else held low
// [RULE8] Pullup-off bit disables slave-select pullup
// [RULE9] Amplifier range decodes slow and range bits
// [RULE10] Slow select forces range zero, blocks writes
// [RULE11] Four slew bits select controlled drive
// [RULE12] Serial pin select routes tx and rx
// [RULE13] SPI pin select places the four SPI lines
// [RULE14] Options clear on reset, write once, readable
// [RULE15] Late writes ignored; outputs follow latched bits
`timescale 1ns/1ns
`default_nettype none
`include "cpo_regs.vh"

module cpo_top
#(
  parameter STAB_LONG  = `CPO_STAB_LONG,
  parameter STAB_SHORT = `CPO_STAB_SHORT
)
(
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   ce,
  input  wire [`CPO_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr,
  input  wire                   rd,
  output reg  [7:0]             rdata_ff,
  input  wire                   stop_mode,
  input  wire                   internal_osc_level,
  input  wire                   external_osc_level,
  input  wire                   ext_clk_tick,
  input  wire                   tb_tick_in,
  input  wire                   serial_txd,
  input  wire                   pta3_in,
  input  wire                   pte1_in,
  output reg                    osc_input_is_clock_ff,
  output reg                    osc_output_is_crystal_ff,
  output reg                    monitor_expect_crystal_ff,
  output reg                    monitor_expect_slow_ff,
  output reg  [1:0]             amp_range_ff,
  output reg                    stab_done_ff,
  output reg                    tb_tick_out_ff,
  output reg                    internal_osc_clock_ff,
  output reg                    external_osc_clock_ff,
  output reg                    ss_pullup_en_ff,
  output reg                    serial_tx_slew_ff,
  output reg                    spi_output_slew_ff,
  output reg                    clock_out_slew_ff,
  output reg                    port_slew_ff,
  output reg                    pta2_txd_ff,
  output reg                    pta2_oe_n_ff,
  output reg                    pte0_txd_ff,
  output reg                    pte0_oe_n_ff,
  output reg                    serial_rxd_ff,
  output reg  [3:0]             spi_on_alt_ff,
  output reg  [3:0]             spi_on_main_ff
);

  ////////////////////////////////////////////////////////////////////
  // Register decode and write-once storage

  wire       wr_cs;
  wire       wr_rp;
  wire [7:0] cs_q;
  wire [7:0] rp_q;
  wire       cs_written;
  wire       rp_written;
  wire [7:0] rp_wdata;
  wire [7:0] rp_clr;
  wire       slow_now;

  assign wr_cs = wr && (addr == `CPO_OFS_CLK_SRC);
  assign wr_rp = wr && (addr == `CPO_OFS_RNG_SLEW_PIN);

  // Slow select as it stands after this cycle's write, so a write to
  // both registers in any order still ends with the range bit clear
  assign slow_now = cs_q[`CPO_CS_SLOW_XTAL] |
                    (wr_cs & !cs_written & wdata[`CPO_CS_SLOW_XTAL]);

  // Range bit cannot be written while slow select is set
  assign rp_wdata = wdata & `CPO_RP_USED_MASK &
                    ~({7'h00, slow_now});                   // [RULE10]
  // Setting slow select forces the stored range bit to zero
  assign rp_clr   = {7'h00, slow_now};                      // [RULE10]

  cpo_wonce_reg
  #(
    .WIDTH   (8),
    .RST_VAL (`CPO_CS_RESET)
  )
  u_cs_reg
  (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .wr         (wr_cs),
    .wdata      (wdata & `CPO_CS_USED_MASK),
    .clr_mask   (8'h00),
    .q_ff       (cs_q),
    .written_ff (cs_written)
  );

  cpo_wonce_reg
  #(
    .WIDTH   (8),
    .RST_VAL (`CPO_RP_RESET)
  )
  u_rp_reg
  (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .wr         (wr_rp),
    .wdata      (rp_wdata),
    .clr_mask   (rp_clr),
    .q_ff       (rp_q),
    .written_ff (rp_written)
  );

  ////////////////////////////////////////////////////////////////////
  // Read port: data valid only in the cycle after the strobe

  // Unmapped addresses read zero, so probing them is harmless
  reg [7:0] nxt_rdata;

  always @*
  begin
    nxt_rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        `CPO_OFS_CLK_SRC:      nxt_rdata = cs_q;            // [RULE14]
        `CPO_OFS_RNG_SLEW_PIN: nxt_rdata = rp_q;            // [RULE14]
        default:               nxt_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Option fields

  wire ext_en;
  wire xtal_en;
  wire slow_sel;
  wire tb_sel;
  wire run_stop;
  wire pu_off;
  wire rng_sel;
  wire ser_sel;
  wire spi_sel;
  wire clocks_on;

  assign ext_en   = cs_q[`CPO_CS_EXT_CLK_EN];
  assign xtal_en  = cs_q[`CPO_CS_CRYSTAL_EN];
  assign slow_sel = cs_q[`CPO_CS_SLOW_XTAL];
  assign tb_sel   = cs_q[`CPO_CS_TB_PRESCALE];
  assign run_stop = cs_q[`CPO_CS_RUN_IN_STOP];
  assign pu_off   = cs_q[`CPO_CS_PULLUP_OFF];
  assign rng_sel  = rp_q[`CPO_RP_RANGE_SEL];
  assign ser_sel  = rp_q[`CPO_RP_SERIAL_PIN];
  assign spi_sel  = rp_q[`CPO_RP_SPI_PIN];

  // Clocks keep running in stop only when asked to
  assign clocks_on = !stop_mode || run_stop;                // [RULE7]

  ////////////////////////////////////////////////////////////////////
  // Stabilization divider, re-armed when the source setup is written

  // Only the first write can change the source, so only it re-arms
  wire stab_done;

  cpo_stab_div
  #(
    .LONG_CNT  (STAB_LONG),
    .SHORT_CNT (STAB_SHORT)
  )
  u_stab
  (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .restart  (wr_cs && !cs_written),
    .run      (ext_en),
    .ext_tick (ext_clk_tick),
    .long_sel (xtal_en),                                    // [RULE4]
    .done_ff  (stab_done)
  );

  ////////////////////////////////////////////////////////////////////
  // Extra timebase prescaler; held in reset while bypassed so the
  // first divided tick is always a full 128 input ticks away

  reg  [6:0] tb_cnt_ff;
  reg  [6:0] nxt_tb_cnt;
  reg        nxt_tb_tick;

  always @*
  begin
    nxt_tb_cnt  = 7'h00;
    nxt_tb_tick = tb_tick_in;                               // [RULE6]
    if (tb_sel)
    begin
      nxt_tb_tick = 1'b0;
      nxt_tb_cnt  = tb_cnt_ff;
      if (tb_tick_in)
      begin
        nxt_tb_cnt  = tb_cnt_ff + 7'h01;
        nxt_tb_tick = (tb_cnt_ff ==
                       (`CPO_TB_DIV - 1) % `CPO_TB_DIV);   // [RULE6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Amplifier range decode

  reg [1:0] nxt_amp;

  always @*
  begin
    case ({slow_sel, rng_sel})                              // [RULE9]
      2'h0:    nxt_amp = `CPO_AMP_8_32MHZ;
      2'h1:    nxt_amp = `CPO_AMP_1_8MHZ;
      2'h2:    nxt_amp = `CPO_AMP_32_100KHZ;
      default: nxt_amp = `CPO_AMP_32_100KHZ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Output registers

  always @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff                  <= 8'h00;
      osc_input_is_clock_ff     <= 1'b0;
      osc_output_is_crystal_ff  <= 1'b0;
      monitor_expect_crystal_ff <= 1'b0;
      monitor_expect_slow_ff    <= 1'b0;
      amp_range_ff              <= 2'h0;
      stab_done_ff              <= 1'b0;
      tb_tick_out_ff            <= 1'b0;
      tb_cnt_ff                 <= 7'h00;
      internal_osc_clock_ff     <= 1'b0;
      external_osc_clock_ff     <= 1'b0;
      ss_pullup_en_ff           <= 1'b1;
      serial_tx_slew_ff         <= 1'b0;
      spi_output_slew_ff        <= 1'b0;
      clock_out_slew_ff         <= 1'b0;
      port_slew_ff              <= 1'b0;
      pta2_txd_ff               <= 1'b1;
      pta2_oe_n_ff              <= 1'b1;
      pte0_txd_ff               <= 1'b1;
      pte0_oe_n_ff              <= 1'b1;
      serial_rxd_ff             <= 1'b1;
      spi_on_alt_ff             <= 4'h0;
      spi_on_main_ff            <= 4'h0;
    end
    else if (ce)
    begin
      rdata_ff                  <= nxt_rdata;
      osc_input_is_clock_ff     <= ext_en;                  // [RULE2]
      osc_output_is_crystal_ff  <= ext_en && xtal_en;       // [RULE1] [RULE2]
      monitor_expect_crystal_ff <= xtal_en;                 // [RULE3]
      monitor_expect_slow_ff    <= slow_sel;                // [RULE5]
      amp_range_ff              <= nxt_amp;                 // [RULE9]
      stab_done_ff              <= stab_done;
      tb_tick_out_ff            <= nxt_tb_tick;
      tb_cnt_ff                 <= nxt_tb_cnt;
      internal_osc_clock_ff     <= internal_osc_level && clocks_on;  // [RULE7]
      external_osc_clock_ff     <= external_osc_level && clocks_on &&
                                   ext_en;                  // [RULE7]
      ss_pullup_en_ff           <= !pu_off;                 // [RULE8]
      serial_tx_slew_ff         <= rp_q[`CPO_RP_TX_SLEW];   // [RULE11]
      spi_output_slew_ff        <= rp_q[`CPO_RP_SPI_SLEW];  // [RULE11]
      clock_out_slew_ff         <= rp_q[`CPO_RP_CLKOUT_SLEW];  // [RULE11]
      port_slew_ff              <= rp_q[`CPO_RP_PORT_SLEW]; // [RULE11]
      // Idle pin drives high so an unselected line looks like a stop bit
      pta2_txd_ff               <= ser_sel ? serial_txd : 1'b1;  // [RULE12]
      pta2_oe_n_ff              <= !ser_sel;                // [RULE12]
      pte0_txd_ff               <= ser_sel ? 1'b1 : serial_txd;  // [RULE12]
      pte0_oe_n_ff              <= ser_sel;                 // [RULE12]
      serial_rxd_ff             <= ser_sel ? pta3_in : pte1_in;  // [RULE12]
      spi_on_alt_ff             <= {4{spi_sel}};            // [RULE13]
      spi_on_main_ff            <= {4{!spi_sel}};           // [RULE13]
    end
  end

endmodule

`default_nettype wire

// File: rtl/cpo_regs.vh
// Purpose: Offsets, field positions, reset values and counts of the
//          clock and pin option block
// Assumes: Byte-wide register port, one register per address
// Notes:   Definitions only
`ifndef CPO_REGS_VH
`define CPO_REGS_VH

// Register offsets
`define CPO_ADDR_W            8
`define CPO_OFS_CLK_SRC       8'h00
`define CPO_OFS_RNG_SLEW_PIN  8'h01

// Clock source option fields
`define CPO_CS_EXT_CLK_EN     0
`define CPO_CS_CRYSTAL_EN     1
`define CPO_CS_SLOW_XTAL      2
`define CPO_CS_TB_PRESCALE    3
`define CPO_CS_RUN_IN_STOP    4
`define CPO_CS_PULLUP_OFF     5
`define CPO_CS_USED_MASK      8'h3f

// Range, slew and pin option fields
`define CPO_RP_RANGE_SEL      0
`define CPO_RP_TX_SLEW        1
`define CPO_RP_SPI_SLEW       2
`define CPO_RP_CLKOUT_SLEW    3
`define CPO_RP_PORT_SLEW      4
`define CPO_RP_SERIAL_PIN     5
`define CPO_RP_SPI_PIN        6
`define CPO_RP_USED_MASK      8'h7f

// Reset values
`define CPO_CS_RESET          8'h00
`define CPO_RP_RESET          8'h00

// Stabilization timeouts in external clock cycles
`define CPO_STAB_LONG         4096
`define CPO_STAB_SHORT        16

// Extra timebase prescale ratio
`define CPO_TB_DIV            128

// Crystal amplifier range codes
`define CPO_AMP_8_32MHZ       2'h0
`define CPO_AMP_1_8MHZ        2'h1
`define CPO_AMP_32_100KHZ     2'h2

`endif

// File: rtl/cpo_wonce_reg.v
// Purpose: One option register that takes a single write after reset
// Assumes: Synchronous active-high reset, clock enable freezes state
// Notes:   Forced-clear mask acts on every enabled cycle, the write cycle included
`timescale 1ns/1ns
`default_nettype none

module cpo_wonce_reg
#(
  parameter       WIDTH    = 8,
  parameter [7:0] RST_VAL  = 8'h00
)
(
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire             wr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [WIDTH-1:0] clr_mask,
  output reg  [WIDTH-1:0] q_ff,
  output reg              written_ff
);

  always @(posedge clk)
  begin
    if (rst)
    begin
      q_ff       <= RST_VAL[WIDTH-1:0];                    // [RULE14]
      written_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && !written_ff)
      begin
        q_ff       <= wdata & ~clr_mask;
        written_ff <= 1'b1;
      end
      else
      begin
        // Later writes fall through silently, no error reported
        q_ff <= q_ff & ~clr_mask;                          // [RULE15]
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/cpo_stab_div.v
// Purpose: External clock stabilization divider of the clock monitor
// Assumes: ext_tick is a one-cycle pulse per external clock period
// Notes:   Restart re-arms the count; done stays high until restart or run goes low
`timescale 1ns/1ns
`default_nettype none
`include "cpo_regs.vh"

module cpo_stab_div
#(
  parameter LONG_CNT  = `CPO_STAB_LONG,
  parameter SHORT_CNT = `CPO_STAB_SHORT
)
(
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire restart,
  input  wire run,
  input  wire ext_tick,
  input  wire long_sel,
  output reg  done_ff
);

  reg  [12:0] cnt_ff;
  wire [12:0] target;

  assign target = long_sel ? LONG_CNT[12:0] : SHORT_CNT[12:0];   // [RULE4]

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff  <= 13'h0000;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (restart || !run)
      begin
        cnt_ff  <= 13'h0000;
        done_ff <= 1'b0;
      end
      else if (ext_tick && !done_ff)
      begin
        cnt_ff  <= cnt_ff + 13'h0001;
        done_ff <= (cnt_ff + 13'h0001) == target;          // [RULE4]
      end
    end
  end

endmodule

`default_nettype wire

// File: sim/cpo_asserts.sv
// Purpose: Port-level checks of the option block
// Assumes: One clock, synchronous active-high reset
// Notes:   Stored bits are observed through register reads
`timescale 1ns/1ns
`default_nettype none
`include "cpo_regs.vh"

module cpo_asserts
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [7:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata_ff,
  input wire logic       stop_mode,
  input wire logic       internal_osc_level,
  input wire logic       tb_tick_in,
  input wire logic       osc_input_is_clock_ff,
  input wire logic       osc_output_is_crystal_ff,
  input wire logic       monitor_expect_crystal_ff,
  input wire logic [1:0] amp_range_ff,
  input wire logic       tb_tick_out_ff,
  input wire logic       internal_osc_clock_ff,
  input wire logic       ss_pullup_en_ff,
  input wire logic [3:0] spi_on_alt_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  // Option outputs checked against read data, inputs and each other
  sequence rd_cs;
    rd && ce && addr == `CPO_OFS_CLK_SRC;
  endsequence
  sequence rd_rp;
    rd && ce && addr == `CPO_OFS_RNG_SLEW_PIN;
  endsequence

  a_rdata_idle_zero:
    assert property (ce && !rd |=> rdata_ff == 8'h00) else $error("read data not zero");
  a_pin_map_follow:
    assert property (rd_cs |=> osc_input_is_clock_ff == rdata_ff[0]
      && monitor_expect_crystal_ff == rdata_ff[1]) else $error("pin function wrong");
  a_crystal_needs_ext:
    assert property (osc_output_is_crystal_ff == (osc_input_is_clock_ff
      && monitor_expect_crystal_ff)) else $error("crystal pin without clock enable");
  a_pullup_inverse:
    assert property (rd_cs |=> ss_pullup_en_ff == !rdata_ff[5]) else $error("pullup wrong");
  a_stop_gates_clk:
    assert property (rd && ce && addr == `CPO_OFS_CLK_SRC && stop_mode && internal_osc_level
      |=> internal_osc_clock_ff == rdata_ff[4]) else $error("stop gating wrong");
  a_run_passes_clk:
    assert property (ce && !stop_mode |=> internal_osc_clock_ff == $past(internal_osc_level))
      else $error("clock not passed");
  a_tick_has_cause:
    assert property (tb_tick_out_ff && $past(ce) |-> $past(tb_tick_in))
      else $error("timebase tick without input tick");
  a_spi_alt_follow:
    assert property (rd_rp |=> spi_on_alt_ff == {4{rdata_ff[6]}}) else $error("spi place wrong");
  a_amp_no_reserved:
    assert property (amp_range_ff != 2'h3) else $error("reserved amplifier range");
  a_range_bit_tie:
    assert property (rd_rp |=> amp_range_ff[0] == rdata_ff[0]) else $error("range bit wrong");

  c_read_rp: cover property (rd_rp);
  c_tick_out: cover property (tb_tick_out_ff);
  c_crystal_on: cover property (osc_output_is_crystal_ff);
endmodule

bind cpo_top cpo_asserts u_chk (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .rd(rd),
  .rdata_ff(rdata_ff), .stop_mode(stop_mode), .internal_osc_level(internal_osc_level),
  .tb_tick_in(tb_tick_in), .osc_input_is_clock_ff(osc_input_is_clock_ff),
  .osc_output_is_crystal_ff(osc_output_is_crystal_ff),
  .monitor_expect_crystal_ff(monitor_expect_crystal_ff), .amp_range_ff(amp_range_ff),
  .tb_tick_out_ff(tb_tick_out_ff), .internal_osc_clock_ff(internal_osc_clock_ff),
  .ss_pullup_en_ff(ss_pullup_en_ff), .spi_on_alt_ff(spi_on_alt_ff));
`default_nettype wire

// File: sim/tb_clock_pin_option_config.sv
// Purpose: Self-checking bench of the option block
// Assumes: Short stabilization counts of 8 and 2
// Notes:   Counts are small so the run stays short
`timescale 1ns/1ns
`default_nettype none
`include "cpo_regs.vh"

module tb_clock_pin_option_config;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       stop = 1'b0;
  logic       ilvl = 1'b0;
  logic       elvl = 1'b0;
  logic       etick = 1'b0;
  logic       ttick = 1'b0;
  logic       txd = 1'b0;
  logic       pta3 = 1'b0;
  logic       pte1 = 1'b1;
  wire  [7:0] rdata;
  wire  [3:0] osc;
  wire  [1:0] amp;
  wire        stab;
  wire        tout;
  wire  [1:0] gclk;
  wire        pull;
  wire  [3:0] slew;
  wire  [3:0] pin;
  wire        rxd;
  wire  [3:0] alt;
  wire  [3:0] main;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         n_out = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (tout === 1'b1) n_out <= n_out + 1;

  cpo_top #(.STAB_LONG(8), .STAB_SHORT(2)) DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata), .stop_mode(stop),
    .internal_osc_level(ilvl), .external_osc_level(elvl), .ext_clk_tick(etick),
    .tb_tick_in(ttick), .serial_txd(txd), .pta3_in(pta3), .pte1_in(pte1),
    .osc_input_is_clock_ff(osc[0]), .osc_output_is_crystal_ff(osc[1]),
    .monitor_expect_crystal_ff(osc[2]), .monitor_expect_slow_ff(osc[3]),
    .amp_range_ff(amp), .stab_done_ff(stab), .tb_tick_out_ff(tout),
    .internal_osc_clock_ff(gclk[0]), .external_osc_clock_ff(gclk[1]),
    .ss_pullup_en_ff(pull), .serial_tx_slew_ff(slew[0]), .spi_output_slew_ff(slew[1]),
    .clock_out_slew_ff(slew[2]), .port_slew_ff(slew[3]), .pta2_txd_ff(pin[0]),
    .pta2_oe_n_ff(pin[1]), .pte0_txd_ff(pin[2]), .pte0_oe_n_ff(pin[3]),
    .serial_rxd_ff(rxd), .spi_on_alt_ff(alt), .spi_on_main_ff(main));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic pulse(input int n, input bit on_tb);
    repeat (n)
    begin
      @(posedge clk);
      if (on_tb) ttick <= 1'b1; else etick <= 1'b1;
      @(posedge clk);
      ttick <= 1'b0;
      etick <= 1'b0;
    end
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_square_clock;
    rd_chk(8'h02, 8'h00);
    wr_reg(`CPO_OFS_CLK_SRC, 8'h01);
    wr_reg(`CPO_OFS_CLK_SRC, 8'h3f);
    rd_chk(`CPO_OFS_CLK_SRC, 8'h01);
    settle;
    chk(osc, 8'h01);
    chk(pull, 8'h01);
    pulse(1, 0);
    settle;
    chk(stab, 8'h00);
    pulse(1, 0);
    settle;
    chk(stab, 8'h01);
    n_out = 0;
    pulse(3, 1);
    settle;
    chk(n_out[7:0], 8'h03);
    @(posedge clk);
    stop <= 1'b1;
    ilvl <= 1'b1;
    elvl <= 1'b1;
    rd_chk(`CPO_OFS_CLK_SRC, 8'h01);
    settle;
    chk(gclk, 8'h00);
    @(posedge clk);
    stop <= 1'b0;
    settle;
    chk(gclk, 8'h03);
    wr_reg(`CPO_OFS_RNG_SLEW_PIN, 8'h7f);
    wr_reg(`CPO_OFS_RNG_SLEW_PIN, 8'h00);
    rd_chk(`CPO_OFS_RNG_SLEW_PIN, 8'h7f);
    settle;
    chk(amp, 8'h01);
    chk(slew, 8'h0f);
    chk({alt, main}, 8'hf0);
    chk(pin, 8'h0c);
    chk(rxd, 8'h00);
    $display("test square clock done");
  endtask

  task automatic t_crystal_slow;
    do_reset;
    rd_chk(`CPO_OFS_CLK_SRC, 8'h00);
    rd_chk(`CPO_OFS_RNG_SLEW_PIN, 8'h00);
    chk(pull, 8'h01);
    chk({alt, main}, 8'h0f);
    wr_reg(`CPO_OFS_CLK_SRC, 8'h3f);
    wr_reg(`CPO_OFS_RNG_SLEW_PIN, 8'h01);
    rd_chk(`CPO_OFS_RNG_SLEW_PIN, 8'h00);
    settle;
    chk(osc, 8'h0f);
    chk(amp, 8'h02);
    chk(pull, 8'h00);
    chk(slew, 8'h00);
    pulse(7, 0);
    settle;
    chk(stab, 8'h00);
    pulse(1, 0);
    settle;
    chk(stab, 8'h01);
    n_out = 0;
    pulse(127, 1);
    settle;
    chk(n_out[7:0], 8'h00);
    pulse(1, 1);
    settle;
    chk(n_out[7:0], 8'h01);
    @(posedge clk);
    stop <= 1'b1;
    txd <= 1'b1;
    pta3 <= 1'b1;
    pte1 <= 1'b0;
    rd_chk(`CPO_OFS_CLK_SRC, 8'h3f);
    settle;
    chk(gclk, 8'h03);
    chk(pin, 8'h07);
    chk(rxd, 8'h00);
    @(posedge clk);
    stop <= 1'b0;
    $display("test crystal slow done");
  endtask

  task automatic t_crystal_alone;
    do_reset;
    wr_reg(`CPO_OFS_CLK_SRC, 8'h02);
    settle;
    chk(osc, 8'h04);
    chk(gclk[1], 8'h00);
    // A write while the clock enable is low must not use up the one write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`CPO_OFS_RNG_SLEW_PIN, 8'h7f);
    @(posedge clk);
    ce <= 1'b1;
    wr_reg(`CPO_OFS_RNG_SLEW_PIN, 8'h20);
    rd_chk(`CPO_OFS_RNG_SLEW_PIN, 8'h20);
    settle;
    chk(pin, 8'h0d);
    chk(rxd, 8'h01);
    $display("test crystal alone done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // The full run needs well under 1500 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_square_clock();
    t_crystal_slow();
    t_crystal_alone();
    print_verdict();
  end
endmodule
`default_nettype wire
